/* File: logic/port_params.svh */
// offsets, field positions and reset values of the port register bank
`ifndef PORT_PARAMS_SVH
`define PORT_PARAMS_SVH
`define OFS_LOOP_W0   32'h2008_4600
`define OFS_LOOP_W1   32'h2008_4604
`define OFS_LOOP_W2   32'h2008_4608
`define OFS_RX_PTR    32'h2008_463C
`define OFS_TX_PTR    32'h2008_4640
`define OFS_SVC_CTRL  32'h2008_4644
`define OFS_DIAG_CTRL 32'h2008_4654
`define OFS_MCLK      32'h2008_4658
`define OFS_IO_CLEAR  32'h2008_4660
`define SVC_EN_BIT    15
`define DIAG_MCLK_BIT 0
`define DIAG_EXT_BIT  1
`define DIAG_DRV_BIT  2
`define DIAG_INT_BIT  3
`define PTR_LSB       1
`define PTR_MSB       15
`define PTR_RESET     15'h0000
`define DIAG_RESET    4'h0
`define LOOP_RESET    9'h000
`endif

/* File: logic/port_pkg.sv */
// shared types of the port register bank
package port_pkg;
    typedef logic [14:0] ptr_field_t;   // buffer address bits 17:3
    typedef logic [3:0]  diag_t;        // diagnostic mode bits
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_W0   = 4'h1,
        SEL_W1   = 4'h2,
        SEL_W2   = 4'h3,
        SEL_RXP  = 4'h4,
        SEL_TXP  = 4'h5,
        SEL_SVC  = 4'h6,
        SEL_DIAG = 4'h7,
        SEL_MCLK = 4'h8,
        SEL_IOC  = 4'h9
    } reg_sel_t;
endpackage : port_pkg

/* File: logic/ptr_if.sv */
// link between a list pointer register and the port controller
interface ptr_if;
    import port_pkg::*;
    logic       reload;    // transaction complete pulse
    ptr_field_t thread;    // thread word of the finished buffer
    ptr_field_t ptr;       // current pointer field
    logic       list_end;  // pointer is zero
    modport store (input reload, input thread, output ptr, output list_end);
    modport ctl   (output reload, output thread, input ptr, input list_end);
endinterface : ptr_if

/* File: logic/list_ptr_reg.sv */
// one list pointer register with guarded processor write and reload
`include "port_params.svh"
module list_ptr_reg
    import port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       wr_req,
    input  wire ptr_field_t wr_data,
    input  wire logic       svc_en,
    ptr_if.store            p
);
    ptr_field_t ptr_r;     // stored pointer field
    ptr_field_t ptr_nxt;   // next pointer field
    logic       wr_ok;     // processor write allowed

    // judged on the value held before this write
    assign wr_ok = wr_req && ((ptr_r == `PTR_RESET) || !svc_en); // R07 R18

    // clear beats reload, reload beats a processor write
    always_comb begin
        if (clear) begin
            ptr_nxt = `PTR_RESET; // R08
        end else if (p.reload) begin
            ptr_nxt = p.thread; // R01 R02
        end else if (wr_ok) begin
            ptr_nxt = wr_data;
        end else begin
            ptr_nxt = ptr_r;
        end
    end

    // pointer storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= `PTR_RESET; // R08
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign p.ptr      = ptr_r;
    assign p.list_end = (ptr_r == `PTR_RESET); // R03

    wr_block_a: assert property (@(posedge clk) disable iff (!rst_n) // R07
        (wr_req && svc_en && ptr_r != `PTR_RESET && !clear && !p.reload)
        |=> ptr_r == $past(ptr_r))
        else $error("guarded pointer write was not ignored");
    reload_a: assert property (@(posedge clk) disable iff (!rst_n) // R01
        (p.reload && !clear) |=> ptr_r == $past(p.thread))
        else $error("pointer did not take thread word");
    ptr_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R08
        clear |=> (p.list_end && ptr_r == `PTR_RESET))
        else $error("pointer not cleared");
    list_end_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
        p.list_end == (p.ptr == `PTR_RESET))
        else $error("end of list flag wrong");
endmodule : list_ptr_reg

/* File: logic/storage_port_regs.sv */
// list pointer and diagnostic control registers of the storage port
//
// Overview of operation
// R01: receive pointer reloads thread word on completion
// R02: transmit pointer reloads thread word on completion
// R03: zero pointer marks end of list
// R04: receive field bits 15:1 hold address 17:3
// R05: transmit field bits 15:1 hold address 17:3
// R06: pointer bit 0 reads zero, written zero
// R07: pointer write only if zero or service off
// R08: pointers clear on reset, power loss, io clear
// R09: pointer bits 31:16 unused, writes ignored
// R10: internal loopback feeds loopback words inward
// R11: software keeps external loopback off then
// R12: driver enable bit, zero after reset
// R13: external loopback words drive bus lines directly
// R14: manual clock pulses per clock register write
// R15: diagnostic bits clear on all resets
// R16: diagnostic bits 31:4 unused, writes ignored
// R17: software uses diagnostics only for test
// R18: write check uses pointer held before write
`include "port_params.svh"
module storage_port_regs
    import port_pkg::*;
#(
    parameter int LOOP_W = 9            // width of each loopback word
)(
    input  wire logic                CLK_SYS,
    input  wire logic                RESETN,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [31:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                DC_POWER_GOOD,
    input  wire logic                PWR_FAIL_CLEAR_INHIBIT,
    input  wire logic                RX_DONE,
    input  wire ptr_field_t          RX_THREAD,
    output ptr_field_t               RX_BUF_ADDR,
    output logic                     RX_LIST_END,
    input  wire logic                TX_DONE,
    input  wire ptr_field_t          TX_THREAD,
    output ptr_field_t               TX_BUF_ADDR,
    output logic                     TX_LIST_END,
    output logic                     INTERNAL_LOOPBACK,
    output logic                     EXTERNAL_LOOPBACK,
    output logic                     DRIVER_ENABLE,
    output logic                     MANUAL_CLOCK_MODE,
    output logic                     MANUAL_CLOCK_PULSE,
    output logic [3*LOOP_W-1:0]      TEST_VECTOR,
    output logic [3*LOOP_W-1:0]      BUS_DIRECT
);
    // bus decode
    logic        setup;                // first cycle of a transfer
    logic        access;               // access phase
    logic        wr_en;                // write takes effect this edge
    reg_sel_t    sel;                  // register addressed
    logic        wr_rxp;               // write to receive pointer
    logic        wr_txp;               // write to transmit pointer
    logic        wr_svc;               // write to service control
    logic        wr_diag;              // write to diagnostic control
    logic        wr_mclk;              // write to clock pulse register
    logic        wr_ioc;               // write to io clear register
    logic        clear_now;            // synchronous clear of the bank
    ptr_field_t  wr_ptr;               // pointer field from write data

    // registers
    logic              svc_en_r;       // port service enable
    diag_t             diag_r;         // diagnostic mode bits
    diag_t             diag_nxt;
    logic [LOOP_W-1:0] loop_r [3];     // loopback words 0..2
    logic [31:0]       rdata_r;        // read data, caught in setup
    logic [31:0]       rdata_nxt;
    logic              mclk_r;         // manual clock pulse
    logic [3*LOOP_W-1:0] words;        // loopback words packed
    logic [3*LOOP_W-1:0] tvec_r;       // inward test vector
    logic [3*LOOP_W-1:0] bdir_r;       // direct bus drive

    // power good filter
    logic        pgood_s1;             // first stage, feeds s2 only
    logic        pgood_s2;
    logic        pgood_s3;
    logic        pgood_f;              // accepted level
    logic        pgood_fall;           // accepted negation

    ptr_if rx_link ();
    ptr_if tx_link ();

    // apb phases; zero wait states, so pready is constant high
    assign setup   = PSEL && !PENABLE;
    assign access  = PSEL && PENABLE;
    assign wr_en   = access && PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = access && (sel == SEL_NONE);
    assign PRDATA  = rdata_r;

    // address decode on the full word address
    assign sel = (PADDR == `OFS_LOOP_W0)   ? SEL_W0   :
                 (PADDR == `OFS_LOOP_W1)   ? SEL_W1   :
                 (PADDR == `OFS_LOOP_W2)   ? SEL_W2   :
                 (PADDR == `OFS_RX_PTR)    ? SEL_RXP  :
                 (PADDR == `OFS_TX_PTR)    ? SEL_TXP  :
                 (PADDR == `OFS_SVC_CTRL)  ? SEL_SVC  :
                 (PADDR == `OFS_DIAG_CTRL) ? SEL_DIAG :
                 (PADDR == `OFS_MCLK)      ? SEL_MCLK :
                 (PADDR == `OFS_IO_CLEAR)  ? SEL_IOC  : SEL_NONE;

    // write strobes, one per register other than the loopback words
    assign wr_rxp  = wr_en && (sel == SEL_RXP);
    assign wr_txp  = wr_en && (sel == SEL_TXP);
    assign wr_svc  = wr_en && (sel == SEL_SVC);
    assign wr_diag = wr_en && (sel == SEL_DIAG);
    assign wr_mclk = wr_en && (sel == SEL_MCLK);
    assign wr_ioc  = wr_en && (sel == SEL_IOC);

    // bit 0 and bits 31:16 are dropped on write
    assign wr_ptr = PWDATA[`PTR_MSB:`PTR_LSB]; // R04 R05 R06 R09

    // any io clear write, or power loss while not inhibited
    assign clear_now = wr_ioc || (pgood_fall && !PWR_FAIL_CLEAR_INHIBIT); // R08 R15

    // power good crosses in; a change counts when s2 and s3 agree
    assign pgood_fall = (pgood_s2 == pgood_s3) && !pgood_s2 && pgood_f;

    // power good synchroniser; starts high so release is quiet
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pgood_s1 <= 1'b1;
            pgood_s2 <= 1'b1;
            pgood_s3 <= 1'b1;
            pgood_f  <= 1'b1;
        end else begin
            pgood_s1 <= DC_POWER_GOOD;
            pgood_s2 <= pgood_s1;
            pgood_s3 <= pgood_s2;
            if (pgood_s2 == pgood_s3) begin
                pgood_f <= pgood_s3;
            end
        end
    end

    // controller side of the pointer links
    assign rx_link.reload = RX_DONE;
    assign rx_link.thread = RX_THREAD;
    assign tx_link.reload = TX_DONE;
    assign tx_link.thread = TX_THREAD;
    assign RX_BUF_ADDR    = rx_link.ptr;
    assign TX_BUF_ADDR    = tx_link.ptr;
    assign RX_LIST_END    = rx_link.list_end;
    assign TX_LIST_END    = tx_link.list_end;

    // receive list pointer
    list_ptr_reg u_rx_ptr (
        .clk     (CLK_SYS),
        .rst_n   (RESETN),
        .clear   (clear_now),
        .wr_req  (wr_rxp),
        .wr_data (wr_ptr),
        .svc_en  (svc_en_r),
        .p       (rx_link.store)
    );

    // transmit list pointer
    list_ptr_reg u_tx_ptr (
        .clk     (CLK_SYS),
        .rst_n   (RESETN),
        .clear   (clear_now),
        .wr_req  (wr_txp),
        .wr_data (wr_ptr),
        .svc_en  (svc_en_r),
        .p       (tx_link.store)
    );

    // diagnostic bits; upper write bits have no effect
    always_comb begin
        if (clear_now) begin
            diag_nxt = `DIAG_RESET; // R15
        end else if (wr_diag) begin
            diag_nxt = PWDATA[3:0]; // R16
        end else begin
            diag_nxt = diag_r;
        end
    end

    // control registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            diag_r   <= `DIAG_RESET; // R12 R15
            svc_en_r <= 1'b0;
        end else begin
            diag_r   <= diag_nxt;
            svc_en_r <= clear_now ? 1'b0 : (wr_svc ? PWDATA[`SVC_EN_BIT] : svc_en_r);
        end
    end

    // loopback words; cleared too, so tests start from a known value
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < 3; i++) begin
                loop_r[i] <= LOOP_W'(`LOOP_RESET);
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (clear_now) begin
                    loop_r[i] <= LOOP_W'(`LOOP_RESET);
                end else if (wr_en && (sel == reg_sel_t'(SEL_W0 + i))) begin
                    loop_r[i] <= PWDATA[LOOP_W-1:0];
                end
            end
        end
    end

    assign words = {loop_r[2], loop_r[1], loop_r[0]};

    // mode outputs straight from the control register; clock pulse and test paths from their own registers
    assign INTERNAL_LOOPBACK = diag_r[`DIAG_INT_BIT];
    assign EXTERNAL_LOOPBACK = diag_r[`DIAG_EXT_BIT];
    assign DRIVER_ENABLE     = diag_r[`DIAG_DRV_BIT]; // R12
    assign MANUAL_CLOCK_MODE = diag_r[`DIAG_MCLK_BIT]; // R14
    assign MANUAL_CLOCK_PULSE = mclk_r;
    assign TEST_VECTOR       = tvec_r;
    assign BUS_DIRECT        = bdir_r;

    // test paths registered, one cycle behind the words
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tvec_r <= '0;
            bdir_r <= '0;
            mclk_r <= 1'b0;
        end else begin
            tvec_r <= diag_r[`DIAG_INT_BIT] ? words : '0; // R10
            bdir_r <= diag_r[`DIAG_EXT_BIT] ? words : '0; // R13
            mclk_r <= wr_mclk && diag_r[`DIAG_MCLK_BIT]; // R14
        end
    end

    // read mux; unused bits return zero
    always_comb begin
        rdata_nxt = '0;
        case (sel)
            SEL_W0:   rdata_nxt[LOOP_W-1:0] = loop_r[0];
            SEL_W1:   rdata_nxt[LOOP_W-1:0] = loop_r[1];
            SEL_W2:   rdata_nxt[LOOP_W-1:0] = loop_r[2];
            SEL_RXP:  rdata_nxt[`PTR_MSB:`PTR_LSB] = rx_link.ptr; // R04 R06 R09
            SEL_TXP:  rdata_nxt[`PTR_MSB:`PTR_LSB] = tx_link.ptr; // R05 R06 R09
            SEL_SVC:  rdata_nxt[`SVC_EN_BIT] = svc_en_r;
            SEL_DIAG: rdata_nxt[3:0] = diag_r; // R16
            default:  rdata_nxt = '0;
        endcase
    end

    // read data caught in the setup cycle, shown through access
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rdata_r <= '0;
        end else if (setup) begin
            rdata_r <= rdata_nxt;
        end
    end

    drv_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R12
        clear_now |=> !DRIVER_ENABLE)
        else $error("driver enable survived clear");
    diag_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R15
        clear_now |=> (diag_r == `DIAG_RESET))
        else $error("diagnostic bits not cleared");
    mclk_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R14
        MANUAL_CLOCK_PULSE == $past(wr_mclk && diag_r[`DIAG_MCLK_BIT]))
        else $error("manual clock pulse wrong");
    ptr_bit0_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R06
        (access && !PWRITE && (sel == SEL_RXP || sel == SEL_TXP)) |-> !PRDATA[0])
        else $error("pointer bit 0 read as one");
    ptr_upper_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R09
        (access && !PWRITE && (sel == SEL_RXP || sel == SEL_TXP)) |-> PRDATA[31:16] == 16'h0000)
        else $error("pointer upper bits not zero");
    int_loop_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R10
        $past(diag_r[`DIAG_INT_BIT]) |-> TEST_VECTOR == $past(words))
        else $error("test vector does not follow words");
    ext_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R13
        ##1 (BUS_DIRECT != '0) |-> $past(diag_r[`DIAG_EXT_BIT]))
        else $error("bus driven outside external loopback");

    // read path follows the stored state; clears reach the pointers and service enable
    rx_field_rd_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R04
        (setup && sel == SEL_RXP) |=> PRDATA[`PTR_MSB:`PTR_LSB] == $past(RX_BUF_ADDR))
        else $error("receive pointer field read wrong");
    tx_field_rd_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R05
        (setup && sel == SEL_TXP) |=> PRDATA[`PTR_MSB:`PTR_LSB] == $past(TX_BUF_ADDR))
        else $error("transmit pointer field read wrong");
    diag_rd_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R16
        (setup && sel == SEL_DIAG) |=> PRDATA == {28'h000_0000, $past(diag_r)})
        else $error("diagnostic bits read wrong");
    pfail_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R08
        (pgood_fall && !PWR_FAIL_CLEAR_INHIBIT) |=> (RX_LIST_END && TX_LIST_END))
        else $error("power loss did not clear pointers");
    idle_vector_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R10
        !$past(diag_r[`DIAG_INT_BIT]) |-> TEST_VECTOR == '0)
        else $error("test vector driven outside internal loopback");
    svc_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN) // R07
        clear_now |=> !svc_en_r)
        else $error("service enable survived clear");
endmodule : storage_port_regs

/* File: tb/port_ctl_model.sv */
// behavioural port controller: ends transfers and hands over thread words
module port_ctl_model
    import port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,      // finish one transfer now
    input  wire logic       to_tx,      // which list the transfer belongs to
    input  wire ptr_field_t thr,        // thread word of the finished buffer
    output logic            rx_done,
    output ptr_field_t      rx_thread,
    output logic            tx_done,
    output ptr_field_t      tx_thread
);
    timeunit 1ns;
    timeprecision 1ps;

    // thread lines carry a word only with the done pulse, and toggle
    // otherwise so a stale word never looks valid to the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_done   <= 1'h0;
            tx_done   <= 1'h0;
            rx_thread <= 15'h5555;
            tx_thread <= 15'h2AAA;
        end else begin
            rx_done   <= start && !to_tx;
            tx_done   <= start && to_tx;
            rx_thread <= (start && !to_tx) ? thr : ~rx_thread;
            tx_thread <= (start && to_tx) ? thr : ~tx_thread;
        end
    end
endmodule : port_ctl_model

/* File: tb/testbench.sv */
// self-checking bench of the storage port register bank
`include "port_params.svh"
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin err_count++; \
    $display("Error %s expected %h seen %h", nm, ex, sn); end end
module testbench
    import port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr;  // clock, reset, bus
    logic [31:0] paddr, pwdata, prdata;                               // bus words
    logic        pgood, inhibit, start, to_tx;                        // power and model control
    ptr_field_t  thr, rx_thr, tx_thr, rx_buf, tx_buf;                 // pointer link
    logic        rx_done, tx_done, rx_end, tx_end;                    // link flags
    logic        int_lb, ext_lb, drv_en, mclk_mode, mclk_pulse;       // diagnostic outputs
    logic [26:0] tvec, bdir;                                          // loopback paths
    logic [1:0]  pulses;                                              // manual clock count
    int          err_count, n_checks, cyc;                            // bookkeeping

    storage_port_regs #(.LOOP_W(9)) i_storage_port_regs (
        .CLK_SYS(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .DC_POWER_GOOD(pgood), .PWR_FAIL_CLEAR_INHIBIT(inhibit),
        .RX_DONE(rx_done), .RX_THREAD(rx_thr), .RX_BUF_ADDR(rx_buf), .RX_LIST_END(rx_end),
        .TX_DONE(tx_done), .TX_THREAD(tx_thr), .TX_BUF_ADDR(tx_buf), .TX_LIST_END(tx_end),
        .INTERNAL_LOOPBACK(int_lb), .EXTERNAL_LOOPBACK(ext_lb), .DRIVER_ENABLE(drv_en),
        .MANUAL_CLOCK_MODE(mclk_mode), .MANUAL_CLOCK_PULSE(mclk_pulse),
        .TEST_VECTOR(tvec), .BUS_DIRECT(bdir));

    port_ctl_model i_port_ctl_model (
        .clk(clk), .rst_n(rstn), .start(start), .to_tx(to_tx), .thr(thr),
        .rx_done(rx_done), .rx_thread(rx_thr), .tx_done(tx_done), .tx_thread(tx_thr));

    // one verdict, reached from the main sequence or the hang guard
    task automatic print_verdict();
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // one bus transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'h1, a, d, q, e);
    endtask : wr

    // read and compare data and error flag
    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] ex,
                      input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'h0, a, 32'h0000_0000, q, e);
        `CHK(nm, ex, q)
        `CHK("slave error", ee, e)
    endtask : rd

    // have the model finish one transfer, then let the reload land
    task automatic finish_xfer(input logic tx, input ptr_field_t t);
        @(posedge clk);
        start <= 1'h1;
        to_tx <= tx;
        thr   <= t;
        @(posedge clk);
        start <= 1'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : finish_xfer

    // count manual clock pulses over the cycles after a clock register write
    task automatic count_pulses();
        wr(`OFS_MCLK, 32'h0000_0001);
        pulses = 2'h0;
        repeat (4) begin
            @(negedge clk);
            pulses = pulses + {1'h0, mclk_pulse};
        end
    endtask : count_pulses

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, start, to_tx, inhibit} = 7'h00;
        {paddr, pwdata} = 64'h0000_0000_0000_0000;
        thr   = 15'h0000;
        pgood = 1'h1;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        `CHK("rx list end", 1'h1, rx_end)
        `CHK("drivers", 1'h0, drv_en)
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_0000, 1'h0);
        rd("tx ptr", `OFS_TX_PTR, 32'h0000_0000, 1'h0);
        rd("diag", `OFS_DIAG_CTRL, 32'h0000_0000, 1'h0);
        wr(`OFS_RX_PTR, 32'hFFFF_FFFE);
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_FFFE, 1'h0);
        `CHK("rx addr", 15'h7FFF, rx_buf)
        `CHK("rx list end", 1'h0, rx_end)
        wr(`OFS_RX_PTR, 32'h0000_0246);
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_0246, 1'h0);
        wr(`OFS_SVC_CTRL, 32'h0000_8000);
        wr(`OFS_RX_PTR, 32'h0000_0000);
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_0246, 1'h0);
        wr(`OFS_TX_PTR, 32'h0002_0ABC);
        rd("tx ptr", `OFS_TX_PTR, 32'h0000_0ABC, 1'h0);
        `CHK("tx addr", 15'h055E, tx_buf)
        finish_xfer(1'h0, 15'h1357);
        `CHK("rx addr", 15'h1357, rx_buf)
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_26AE, 1'h0);
        finish_xfer(1'h1, 15'h0000);
        `CHK("tx list end", 1'h1, tx_end)
        wr(`OFS_TX_PTR, 32'h0000_0010);
        rd("tx ptr", `OFS_TX_PTR, 32'h0000_0010, 1'h0);
        rd("unmapped", 32'h2008_4650, 32'h0000_0000, 1'h1);
        wr(`OFS_LOOP_W0, 32'h0000_01A5);
        wr(`OFS_LOOP_W1, 32'h0000_00C3);
        wr(`OFS_LOOP_W2, 32'h0000_0155);
        // internal loopback alone, external kept off
        wr(`OFS_DIAG_CTRL, 32'h0000_0008);
        repeat (2) @(negedge clk);
        `CHK("test vector", {9'h155, 9'h0C3, 9'h1A5}, tvec)
        `CHK("bus direct", 27'h000_0000, bdir)
        `CHK("internal loop", 1'h1, int_lb)
        wr(`OFS_DIAG_CTRL, 32'h0000_0002);
        repeat (2) @(negedge clk);
        `CHK("bus direct", {9'h155, 9'h0C3, 9'h1A5}, bdir)
        `CHK("test vector", 27'h000_0000, tvec)
        `CHK("external loop", 1'h1, ext_lb)
        wr(`OFS_DIAG_CTRL, 32'h0000_0004);
        @(negedge clk);
        `CHK("drivers", 1'h1, drv_en)
        wr(`OFS_DIAG_CTRL, 32'h0000_0001);
        count_pulses();
        `CHK("manual clock", 2'h1, pulses)
        `CHK("manual mode", 1'h1, mclk_mode)
        wr(`OFS_DIAG_CTRL, 32'h0000_0000);
        count_pulses();
        `CHK("manual clock", 2'h0, pulses)
        wr(`OFS_DIAG_CTRL, 32'hFFFF_FFF7);
        rd("diag", `OFS_DIAG_CTRL, 32'h0000_0007, 1'h0);
        wr(`OFS_IO_CLEAR, 32'h0000_0000);
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_0000, 1'h0);
        rd("tx ptr", `OFS_TX_PTR, 32'h0000_0000, 1'h0);
        rd("diag", `OFS_DIAG_CTRL, 32'h0000_0000, 1'h0);
        // power loss while inhibited must leave state alone
        wr(`OFS_RX_PTR, 32'h0000_0002);
        wr(`OFS_DIAG_CTRL, 32'h0000_0004);
        @(posedge clk);
        inhibit <= 1'h1;
        pgood   <= 1'h0;
        repeat (8) @(posedge clk);
        pgood <= 1'h1;
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_0002, 1'h0);
        rd("diag", `OFS_DIAG_CTRL, 32'h0000_0004, 1'h0);
        inhibit <= 1'h0;
        repeat (8) @(posedge clk);
        pgood <= 1'h0;
        repeat (8) @(posedge clk);
        pgood <= 1'h1;
        rd("rx ptr", `OFS_RX_PTR, 32'h0000_0000, 1'h0);
        rd("diag", `OFS_DIAG_CTRL, 32'h0000_0000, 1'h0);
        print_verdict();
    end
endmodule : testbench
